// File: verilog/pfsp_port_mux.sv
// Purpose: shared printer / single floppy port pin logic
// Assumes: pins arrive asynchronous; user side on ref_clk
// Notes:   mode caught once after reset release
// Functional notes
// - Mode sampled at boot, then held fixed
// - Select high or open gives printer functions
// - Select low gives floppy functions
// - Modes exclusive; other function fully idle
// - Floppy mode serves exactly one drive
// - Strobe low clocks data into printer
// - Auto line feed output, active low
// - Data bus works both directions
// - Printer initialise held while output low
// - Printer select output, active low
// - Density output shows low or high rate
// - Each read data fall is one flux
// - Direction low step in, high out
// - Step pulses at programmed rate per move
// - Write data falls are precompensated flux changes
// - Write gate low enables drive writing
// - Drive select and motor on outputs
`timescale 1ns/1ps
`include "pfsp_consts.svh"
`default_nettype none
module pfsp_port_mux #(
    parameter int STEP_UNIT_CYC = `PFSP_STEP_UNIT_NS / `PFSP_CLK_NS
) (
    // Clock, reset, enable
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       clk_en,
    // Boot strap pin
    input  wire logic       port_function_select,
    // Shared pins
    input  wire logic [4:0] shared_stat_pin,
    output logic      [3:0] shared_ctl_n,
    input  wire logic [7:0] port_data_bus_in,
    output logic      [7:0] port_data_bus_out,
    output logic      [7:0] port_data_bus_oe,
    // Mode report
    output logic            mode_locked,
    output logic            mode_parallel,
    // Printer user side
    input  wire logic       pp_write_req,
    input  wire logic [7:0] pp_wdata,
    output logic            pp_ready,
    input  wire logic       pp_read_dir,
    output logic      [7:0] pp_rdata,
    input  wire logic       pp_autofeed,
    input  wire logic       pp_init,
    input  wire logic       pp_choose,
    output logic            pp_ack_pulse,
    output logic            pp_busy,
    output logic            pp_paper_out,
    output logic            pp_error,
    output logic            pp_online,
    // Floppy user side
    input  wire logic       fd_high_density,
    input  wire logic       fd_drive_on,
    input  wire logic       fd_motor_on,
    input  wire logic       fd_head1,
    input  wire logic       fd_step_out,
    input  wire logic [3:0] fd_step_rate,
    input  wire logic [7:0] fd_seek_count,
    input  wire logic       fd_seek_req,
    output logic            fd_seek_ready,
    output logic            fd_seek_busy,
    input  wire logic       fd_write_en,
    input  wire logic       fd_flux_write,
    input  wire logic [1:0] fd_precomp,
    output logic            fd_flux_pulse,
    output logic            fd_index,
    output logic            fd_track_zero,
    output logic            fd_write_protect,
    output logic            fd_disk_changed
);
    localparam logic [7:0]  SETUP_C  = 8'(`PFSP_CYC_UP(`PFSP_SETUP_NS));
    localparam logic [7:0]  STROBE_C = 8'(`PFSP_CYC_UP(`PFSP_STROBE_NS));
    localparam logic [7:0]  HOLD_C   = 8'(`PFSP_CYC_UP(`PFSP_HOLD_NS));
    localparam logic [23:0] STLOW_C  = 24'(`PFSP_CYC_UP(`PFSP_STEP_LOW_NS));
    localparam logic [23:0] UNIT_C   = 24'(STEP_UNIT_CYC);
    localparam logic [1:0]  WLOW_C   = 2'(`PFSP_CYC_UP(`PFSP_WLOW_NS));

    logic [`PFSP_SYNC_W-1:0] sy_lvl;
    logic [`PFSP_SYNC_W-1:0] sy_fall;
    logic [3:0]              boot_cnt_q;
    logic                    locked_q;
    pfsp_pkg::pfsp_mode_e    mode_q;
    logic                    par_on;
    logic                    fd_on;
    pfsp_pkg::pfsp_pp_e      pp_state_q;
    logic [7:0]              pp_cnt_q;
    logic [7:0]              pp_data_q;
    logic                    pp_take;
    logic                    autofeed_q;
    logic                    init_q;
    logic                    choose_q;
    logic                    dir_rd_q;
    pfsp_pkg::pfsp_seek_e    sk_state_q;
    logic [23:0]             sk_cnt_q;
    logic [23:0]             sk_period_q;
    logic [7:0]              sk_left_q;
    logic                    sk_dir_q;
    logic                    sk_take;
    logic                    density_q;
    logic                    drive_q;
    logic                    motor_q;
    logic                    head1_q;
    logic                    gate_q;
    logic [2:0]              dl_q;
    logic                    tap;
    logic [1:0]              wl_cnt_q;
    logic [3:0]              ctl_d;
    logic [7:0]              dbo_d;
    logic [7:0]              dboe_d;

    // ************
    // Pin synchronisers
    // ************
    pfsp_pin_sync #(.W(`PFSP_SYNC_W)) u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .clk_en  (clk_en),
        .pin_in  ({port_function_select, port_data_bus_in, shared_stat_pin}),
        .lvl_q   (sy_lvl),
        .fall_q  (sy_fall)
    );

    // ************
    // Boot mode capture
    // ************
    // Settle count, then freeze the strap
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            boot_cnt_q <= 4'h0;
            locked_q   <= 1'b0;
            mode_q     <= pfsp_pkg::PFSP_MODE_PARALLEL;
        end else if (clk_en && !locked_q) begin
            if (boot_cnt_q == `PFSP_BOOT_SETTLE) begin
                locked_q <= 1'b1;
                mode_q   <= sy_lvl[`PFSP_SY_SEL] ? pfsp_pkg::PFSP_MODE_PARALLEL
                                                 : pfsp_pkg::PFSP_MODE_FLOPPY;
            end else begin
                boot_cnt_q <= boot_cnt_q + 4'h1;
            end
        end
    end

    // Mode qualifiers
    assign par_on        = locked_q && mode_q == pfsp_pkg::PFSP_MODE_PARALLEL;
    assign fd_on         = locked_q && mode_q == pfsp_pkg::PFSP_MODE_FLOPPY;
    assign mode_locked   = locked_q;
    assign mode_parallel = par_on;

    // ************
    // Printer side
    // ************
    assign pp_ready = par_on && pp_state_q == pfsp_pkg::PP_IDLE && !dir_rd_q
                      && !sy_lvl[`PFSP_ST_BUSY_TRACK];
    assign pp_take  = pp_write_req && pp_ready;

    // Printer control levels
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            autofeed_q <= 1'b0;
            init_q     <= 1'b0;
            choose_q   <= 1'b0;
            dir_rd_q   <= 1'b0;
        end else if (clk_en) begin
            autofeed_q <= pp_autofeed;
            init_q     <= pp_init;
            choose_q   <= pp_choose;
            dir_rd_q   <= pp_read_dir;
        end
    end

    // Strobe sequence: setup, strobe, hold
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pp_state_q <= pfsp_pkg::PP_IDLE;
            pp_cnt_q   <= 8'h00;
            pp_data_q  <= 8'h00;
        end else if (clk_en) begin
            case (pp_state_q)
                pfsp_pkg::PP_IDLE: begin
                    if (pp_take) begin
                        pp_data_q  <= pp_wdata;
                        pp_cnt_q   <= SETUP_C - 8'h01;
                        pp_state_q <= pfsp_pkg::PP_SETUP;
                    end
                end
                pfsp_pkg::PP_SETUP: begin
                    if (pp_cnt_q == 8'h00) begin
                        pp_cnt_q   <= STROBE_C - 8'h01;
                        pp_state_q <= pfsp_pkg::PP_STROBE;
                    end else begin
                        pp_cnt_q <= pp_cnt_q - 8'h01;
                    end
                end
                pfsp_pkg::PP_STROBE: begin
                    if (pp_cnt_q == 8'h00) begin
                        pp_cnt_q   <= HOLD_C - 8'h01;
                        pp_state_q <= pfsp_pkg::PP_HOLD;
                    end else begin
                        pp_cnt_q <= pp_cnt_q - 8'h01;
                    end
                end
                pfsp_pkg::PP_HOLD: begin
                    if (pp_cnt_q == 8'h00) begin
                        pp_state_q <= pfsp_pkg::PP_IDLE;
                    end else begin
                        pp_cnt_q <= pp_cnt_q - 8'h01;
                    end
                end
                default: pp_state_q <= pfsp_pkg::PP_IDLE;
            endcase
        end
    end

    // Status and read data toward the user
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pp_rdata         <= 8'h00;
            pp_ack_pulse     <= 1'b0;
            pp_busy          <= 1'b0;
            pp_paper_out     <= 1'b0;
            pp_error         <= 1'b0;
            pp_online        <= 1'b0;
            fd_flux_pulse    <= 1'b0;
            fd_index         <= 1'b0;
            fd_track_zero    <= 1'b0;
            fd_write_protect <= 1'b0;
            fd_disk_changed  <= 1'b0;
        end else if (clk_en) begin
            if (par_on && dir_rd_q) begin
                pp_rdata <= sy_lvl[`PFSP_SY_DATA_LSB +: 8];
            end
            pp_ack_pulse     <= par_on && sy_fall[`PFSP_ST_ACK_INDEX];
            pp_busy          <= par_on && sy_lvl[`PFSP_ST_BUSY_TRACK];
            pp_paper_out     <= par_on && sy_lvl[`PFSP_ST_PAPER_WPROT];
            pp_error         <= par_on && !sy_lvl[`PFSP_ST_ERROR_FLUX];
            pp_online        <= par_on && sy_lvl[`PFSP_ST_ONLINE_CHG];
            fd_flux_pulse    <= fd_on && sy_fall[`PFSP_ST_ERROR_FLUX];
            fd_index         <= fd_on && !sy_lvl[`PFSP_ST_ACK_INDEX];
            fd_track_zero    <= fd_on && !sy_lvl[`PFSP_ST_BUSY_TRACK];
            fd_write_protect <= fd_on && !sy_lvl[`PFSP_ST_PAPER_WPROT];
            fd_disk_changed  <= fd_on && !sy_lvl[`PFSP_ST_ONLINE_CHG];
        end
    end

    // ************
    // Floppy side
    // ************
    // Single drive controls
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            density_q <= 1'b0;
            drive_q   <= 1'b0;
            motor_q   <= 1'b0;
            head1_q   <= 1'b0;
            gate_q    <= 1'b0;
        end else if (clk_en) begin
            density_q <= fd_high_density;
            drive_q   <= fd_on && fd_drive_on;
            motor_q   <= fd_on && fd_motor_on;
            head1_q   <= fd_head1;
            gate_q    <= fd_on && fd_write_en
                         && sy_lvl[`PFSP_ST_PAPER_WPROT];
        end
    end

    assign fd_seek_ready = fd_on && sk_state_q == pfsp_pkg::SK_IDLE;
    assign fd_seek_busy  = sk_state_q != pfsp_pkg::SK_IDLE;
    assign sk_take       = fd_seek_req && fd_seek_ready && fd_seek_count != 8'h00;

    // Seek: one step pulse per move at programmed period
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sk_state_q  <= pfsp_pkg::SK_IDLE;
            sk_cnt_q    <= 24'h000000;
            sk_period_q <= 24'h000000;
            sk_left_q   <= 8'h00;
            sk_dir_q    <= 1'b0;
        end else if (clk_en) begin
            case (sk_state_q)
                pfsp_pkg::SK_IDLE: begin
                    if (sk_take) begin
                        sk_left_q   <= fd_seek_count;
                        sk_dir_q    <= fd_step_out;
                        sk_period_q <= 24'({20'h00000, fd_step_rate} + 24'h1) * UNIT_C;
                        sk_cnt_q    <= STLOW_C - 24'h1;
                        sk_state_q  <= pfsp_pkg::SK_LOW;
                    end
                end
                pfsp_pkg::SK_LOW: begin
                    if (sk_cnt_q == 24'h0) begin
                        sk_cnt_q   <= sk_period_q - STLOW_C - 24'h1;
                        sk_state_q <= pfsp_pkg::SK_GAP;
                    end else begin
                        sk_cnt_q <= sk_cnt_q - 24'h1;
                    end
                end
                pfsp_pkg::SK_GAP: begin
                    if (sk_cnt_q == 24'h0) begin
                        sk_left_q <= sk_left_q - 8'h01;
                        sk_cnt_q  <= STLOW_C - 24'h1;
                        if (sk_left_q == 8'h01) begin
                            sk_state_q <= pfsp_pkg::SK_IDLE;
                        end else begin
                            sk_state_q <= pfsp_pkg::SK_LOW;
                        end
                    end else begin
                        sk_cnt_q <= sk_cnt_q - 24'h1;
                    end
                end
                default: sk_state_q <= pfsp_pkg::SK_IDLE;
            endcase
        end
    end

    // Write precompensation taps: early, nominal, late
    always_comb begin
        case (fd_precomp)
            `PFSP_PRECOMP_EARLY: tap = dl_q[0];
            `PFSP_PRECOMP_LATE: tap = dl_q[2];
            default:            tap = dl_q[1];
        endcase
    end

    // Flux delay line and low pulse timer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dl_q     <= 3'h0;
            wl_cnt_q <= 2'h0;
        end else if (clk_en) begin
            dl_q <= {dl_q[1:0], fd_flux_write && gate_q};
            if (tap) begin
                wl_cnt_q <= WLOW_C;
            end else if (wl_cnt_q != 2'h0) begin
                wl_cnt_q <= wl_cnt_q - 2'h1;
            end
        end
    end

    // ************
    // Pin multiplexer
    // ************
    // Idle released unless a mode owns the pins
    always_comb begin
        ctl_d  = 4'hf;
        dbo_d  = 8'hff;
        dboe_d = 8'h00;
        if (par_on) begin
            ctl_d[`PFSP_CT_STROBE_DRV] = pp_state_q != pfsp_pkg::PP_STROBE;
            ctl_d[`PFSP_CT_FEED_SPIN]  = !autofeed_q;
            ctl_d[`PFSP_CT_INIT_HEAD]  = !init_q;
            ctl_d[`PFSP_CT_CHOOSE_DIR] = !choose_q;
            dbo_d                      = pp_data_q;
            dboe_d                     = {8{!dir_rd_q}};
        end else if (fd_on) begin
            ctl_d[`PFSP_CT_STROBE_DRV] = !drive_q;
            ctl_d[`PFSP_CT_FEED_SPIN]  = !motor_q;
            ctl_d[`PFSP_CT_INIT_HEAD]  = head1_q;
            ctl_d[`PFSP_CT_CHOOSE_DIR] = sk_dir_q;
            dbo_d[`PFSP_DP_DENSITY]    = density_q;
            dbo_d[`PFSP_DP_STEP]       = sk_state_q != pfsp_pkg::SK_LOW;
            dbo_d[`PFSP_DP_WDATA]      = wl_cnt_q == 2'h0;
            dbo_d[`PFSP_DP_WRITE_ENABLE_GATE_N]      = !gate_q;
            dboe_d                     = `PFSP_FD_DATA_OE;
        end
    end

    // Registered pin drivers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            shared_ctl_n      <= 4'hf;
            port_data_bus_out <= 8'hff;
            port_data_bus_oe  <= 8'h00;
        end else if (clk_en) begin
            shared_ctl_n      <= ctl_d;
            port_data_bus_out <= dbo_d;
            port_data_bus_oe  <= dboe_d;
        end
    end

    // ************
    // Checks
    // ************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic [7:0] st_len_q;
    // Strobe low length helper
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_len_q <= 8'h00;
        end else if (clk_en) begin
            st_len_q <= shared_ctl_n[`PFSP_CT_STROBE_DRV] ? 8'h00 : st_len_q + 8'h01;
        end
    end

    AST_MODE_FROZEN: assert property (locked_q |=> locked_q && $stable(mode_q))
        else $error("boot mode changed after lock");
    AST_PAR_DATA_OE: assert property (clk_en && par_on && !dir_rd_q
        |=> port_data_bus_oe == 8'hff)
        else $error("printer data not driven");
    AST_FD_DATA_OE: assert property (clk_en && fd_on
        |=> port_data_bus_oe == `PFSP_FD_DATA_OE)
        else $error("floppy pin enables wrong");
    AST_EXCLUSIVE: assert property (par_on |-> !fd_seek_busy && !gate_q
        && !drive_q && !fd_flux_pulse)
        else $error("floppy active in parallel mode");
    AST_STROBE_LEN: assert property ($rose(shared_ctl_n[`PFSP_CT_STROBE_DRV]) && par_on
        |-> st_len_q == STROBE_C)
        else $error("strobe width wrong");
    AST_STEP_START: assert property (clk_en && sk_take ##1 clk_en
        |=> !port_data_bus_out[`PFSP_DP_STEP])
        else $error("step pulse did not start");
    AST_DIR_HOLD: assert property (fd_seek_busy && $past(fd_seek_busy)
        && $past(fd_seek_busy, 2) |-> $stable(shared_ctl_n[`PFSP_CT_CHOOSE_DIR]))
        else $error("direction moved during seek");
    AST_GATE_SAFE: assert property (clk_en && !fd_write_en ##1 clk_en
        |=> port_data_bus_out[`PFSP_DP_WRITE_ENABLE_GATE_N] || !port_data_bus_oe[`PFSP_DP_WRITE_ENABLE_GATE_N])
        else $error("write gate active without write");
    AST_FLUX_WRITE: assert property (clk_en && fd_flux_write && gate_q
        && fd_precomp == `PFSP_PRECOMP_NOM
        ##1 (clk_en && fd_precomp == `PFSP_PRECOMP_NOM) [*2] ##1 clk_en
        |=> !port_data_bus_out[`PFSP_DP_WDATA])
        else $error("write flux not on wire");
    AST_FLUX_READ: assert property (clk_en && fd_on
        && sy_fall[`PFSP_ST_ERROR_FLUX] |=> fd_flux_pulse)
        else $error("read flux lost");

    COV_PP_WRITE: cover property ($rose(shared_ctl_n[`PFSP_CT_STROBE_DRV]) && par_on);
    COV_SEEK_DONE: cover property ($fell(fd_seek_busy));
    COV_WRITE: cover property ($fell(port_data_bus_out[`PFSP_DP_WDATA]) && fd_on);
    COV_FLOPPY: cover property ($rose(fd_on));
endmodule
`default_nettype wire

// File: verilog/pfsp_consts.svh
// Purpose: constants of the shared printer/floppy port
// Assumes: 10 MHz ref_clk
// Notes:   pin slots serve both modes
`ifndef PFSP_CONSTS_SVH
`define PFSP_CONSTS_SVH
`define PFSP_CLK_NS         100
`define PFSP_CYC_UP(ns)     (((ns) + `PFSP_CLK_NS - 1) / `PFSP_CLK_NS)
`define PFSP_SETUP_NS       500
`define PFSP_STROBE_NS      1000
`define PFSP_HOLD_NS        500
`define PFSP_STEP_LOW_NS    3000
`define PFSP_STEP_UNIT_NS   500000
`define PFSP_WLOW_NS        200
`define PFSP_BOOT_SETTLE    4'h4
`define PFSP_SYNC_W         14
`define PFSP_SY_DATA_LSB    5
`define PFSP_SY_SEL         13
// Status inputs: parallel / floppy meaning
`define PFSP_ST_ACK_INDEX   0
`define PFSP_ST_BUSY_TRACK  1
`define PFSP_ST_PAPER_WPROT 2
`define PFSP_ST_ERROR_FLUX  3
`define PFSP_ST_ONLINE_CHG  4
// Control outputs: parallel / floppy meaning
`define PFSP_CT_STROBE_DRV  0
`define PFSP_CT_FEED_SPIN   1
`define PFSP_CT_INIT_HEAD   2
`define PFSP_CT_CHOOSE_DIR  3
// Data pins carrying floppy outputs
`define PFSP_DP_DENSITY     0
`define PFSP_DP_STEP        1
`define PFSP_DP_WDATA       2
`define PFSP_DP_WRITE_ENABLE_GATE_N       3
`define PFSP_FD_DATA_OE     8'h0f
`define PFSP_PRECOMP_EARLY  2'h0
`define PFSP_PRECOMP_NOM    2'h1
`define PFSP_PRECOMP_LATE   2'h2
`endif

// File: verilog/pfsp_pkg.sv
// Purpose: types of the shared printer/floppy port
// Assumes: nothing
// Notes:   states only, no numbers
`default_nettype none
package pfsp_pkg;
    typedef enum logic {PFSP_MODE_FLOPPY, PFSP_MODE_PARALLEL} pfsp_mode_e;
    typedef enum logic [1:0] {PP_IDLE, PP_SETUP, PP_STROBE, PP_HOLD} pfsp_pp_e;
    typedef enum logic [1:0] {SK_IDLE, SK_LOW, SK_GAP} pfsp_seek_e;
endpackage
`default_nettype wire

// File: verilog/pfsp_pin_sync.sv
// Purpose: two-flop synchroniser with falling-edge pulses
// Assumes: inputs asynchronous to ref_clk
// Notes:   first stage read only by second
`timescale 1ns/1ps
`include "pfsp_consts.svh"
`default_nettype none
module pfsp_pin_sync #(
    parameter int W = `PFSP_SYNC_W
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic         clk_en,
    // Pins and results
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] lvl_q,
    output logic      [W-1:0] fall_q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s3_q;

    // ************
    // Per-bit stages
    // ************
    for (genvar i = 0; i < W; i++) begin : g_bit
        // Meta stage, level stage, edge history
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                s1_q[i]   <= 1'b1;
                lvl_q[i]  <= 1'b1;
                s3_q[i]   <= 1'b1;
                fall_q[i] <= 1'b0;
            end else if (clk_en) begin
                s1_q[i]   <= pin_in[i];
                lvl_q[i]  <= s1_q[i];
                s3_q[i]   <= lvl_q[i];
                fall_q[i] <= s3_q[i] & ~lvl_q[i];
            end
        end
    end

    // Level arrives two edges after the pin
    AST_SYNC_DELAY: assert property (@(posedge ref_clk) disable iff (rst)
        $past(clk_en) && $past(clk_en, 2) && !$past(rst) && !$past(rst, 2)
        |-> lvl_q == $past(pin_in, 2))
        else $error("sync level not two edges behind pin");
endmodule
`default_nettype wire

// File: verif/pfsp_far_model.sv
// Purpose: printer or single floppy drive on the shared pins
// Assumes: pins as driven by pfsp_port_mux
// Notes:   released data pins show a fixed peripheral byte
`timescale 1ns/1ps
`default_nettype none
module pfsp_far_model (
    // Clock and mode
    input  wire logic       ref_clk,
    input  wire logic       parallel,
    // Pins from the port
    input  wire logic [3:0] ctl_n,
    input  wire logic [7:0] bus_out,
    input  wire logic [7:0] bus_oe,
    // Raw read flux from the bench
    input  wire logic       flux_n,
    // Pins to the port
    output logic      [4:0] stat,
    output logic      [7:0] bus_in
);
    logic [3:0] ack_cnt_q = 4'h0;
    // Printer acknowledges a few cycles after each strobe
    always_ff @(posedge ref_clk) begin
        if (parallel && $rose(ctl_n[0])) ack_cnt_q <= 4'h6;
        else if (ack_cnt_q != 4'h0) ack_cnt_q <= ack_cnt_q - 4'h1;
    end
    // Status lines: online, no error, paper, idle; drive: track 0 only
    assign stat = parallel ? {4'hc, !(ack_cnt_q inside {[4'h1:4'h3]})}
                           : {1'h1, flux_n, 1'h1, 1'h0, 1'h1};
    // Peripheral byte wherever the port lets go of the bus
    assign bus_in = (bus_oe & bus_out) | (~bus_oe & 8'h5a);
endmodule
`default_nettype wire

// File: verif/tb.sv
// Purpose: self-checking bench of the shared port
// Assumes: 10 MHz ref_clk, inputs changed at falling edge
// Notes:   short step unit keeps seeks brief
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic ref_clk = 0, rst = 1, clk_en = 1, port_function_select = 1, flux_n = 1;
    logic pp_write_req = 0, pp_read_dir = 0, pp_autofeed = 0, pp_init = 0, pp_choose = 0;
    logic fd_high_density = 1, fd_drive_on = 1, fd_motor_on = 1, fd_head1 = 1;
    logic fd_step_out = 0, fd_seek_req = 0, fd_write_en = 0, fd_flux_write = 0;
    logic [7:0] pp_wdata = 8'h00, fd_seek_count = 8'h00, port_data_bus_in;
    logic [3:0] fd_step_rate = 4'h0, shared_ctl_n;
    logic [1:0] fd_precomp = 2'h1;
    logic [4:0] shared_stat_pin;
    logic [7:0] port_data_bus_out, port_data_bus_oe, pp_rdata;
    logic mode_locked, mode_parallel, pp_ready, pp_ack_pulse, pp_busy, pp_paper_out;
    logic pp_error, pp_online, fd_seek_ready, fd_seek_busy, fd_flux_pulse, fd_index;
    logic fd_track_zero, fd_write_protect, fd_disk_changed;
    int error_cnt = 0, checks_done = 0;
    // ****************
    // Clock, design, far side
    // ****************
    always #50 ref_clk = !ref_clk;
    pfsp_port_mux #(.STEP_UNIT_CYC(40)) dut (.ref_clk, .rst, .clk_en, .port_function_select,
        .shared_stat_pin, .shared_ctl_n, .port_data_bus_in, .port_data_bus_out,
        .port_data_bus_oe, .mode_locked, .mode_parallel, .pp_write_req, .pp_wdata, .pp_ready,
        .pp_read_dir, .pp_rdata, .pp_autofeed, .pp_init, .pp_choose, .pp_ack_pulse, .pp_busy,
        .pp_paper_out, .pp_error, .pp_online, .fd_high_density, .fd_drive_on, .fd_motor_on,
        .fd_head1, .fd_step_out, .fd_step_rate, .fd_seek_count, .fd_seek_req, .fd_seek_ready,
        .fd_seek_busy, .fd_write_en, .fd_flux_write, .fd_precomp, .fd_flux_pulse, .fd_index,
        .fd_track_zero, .fd_write_protect, .fd_disk_changed);
    pfsp_far_model far (.ref_clk, .parallel(mode_parallel), .ctl_n(shared_ctl_n),
        .bus_out(port_data_bus_out), .bus_oe(port_data_bus_oe), .flux_n,
        .stat(shared_stat_pin), .bus_in(port_data_bus_in));
    // ****************
    // Checking and run control
    // ****************
    task automatic chk(string nm, logic [7:0] got, logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Reset for three cycles, then wait past the mode lock
    task automatic boot(logic s);
        rst = 1;
        port_function_select = s;
        repeat (3) @(negedge ref_clk);
        rst = 0;
        repeat (8) @(negedge ref_clk);
        chk("locked", mode_locked, 8'h01);
        chk("mode", mode_parallel, s);
    endtask
    // Printer byte, strobe width, ack, controls, bus turnaround
    task automatic t_par();
        int n;
        boot(1);
        port_function_select = 0;
        {pp_autofeed, pp_init, pp_choose} = 3'h7;
        pp_wdata = 8'ha5;
        repeat (3) @(negedge ref_clk);
        chk("mode held", mode_parallel, 8'h01);
        chk("ctl", shared_ctl_n, 8'h01);
        chk("ready", pp_ready, 8'h01);
        pp_write_req = 1;
        @(negedge ref_clk);
        pp_write_req = 0;
        repeat (6) @(negedge ref_clk);
        chk("strobe on", shared_ctl_n[0], 8'h00);
        chk("data", port_data_bus_out, 8'ha5);
        chk("oe", port_data_bus_oe, 8'hff);
        repeat (9) @(negedge ref_clk);
        chk("strobe held", shared_ctl_n[0], 8'h00);
        @(negedge ref_clk);
        chk("strobe off", shared_ctl_n[0], 8'h01);
        for (n = 0; n < 40 && !pp_ack_pulse; n++) @(negedge ref_clk);
        chk("ack", pp_ack_pulse, 8'h01);
        pp_read_dir = 1;
        repeat (6) @(negedge ref_clk);
        chk("rd oe", port_data_bus_oe, 8'h00);
        chk("rdata", pp_rdata, 8'h5a);
        chk("online", {pp_online, pp_error, pp_paper_out, pp_busy}, 8'h08);
        $display("parallel test done");
    endtask
    // Floppy outputs, two-step seek, write gate, flux both ways
    task automatic t_fd();
        int n, f;
        logic p;
        boot(0);
        repeat (3) @(negedge ref_clk);
        chk("fd ctl", shared_ctl_n, 8'h04);
        chk("fd oe", port_data_bus_oe, 8'h0f);
        chk("fd pins", port_data_bus_out[3:0], 8'h0f);
        chk("drive stat", {fd_track_zero, fd_index, fd_disk_changed, fd_write_protect}, 8'h08);
        fd_seek_count = 8'h02;
        fd_seek_req = 1;
        @(negedge ref_clk);
        fd_seek_req = 0;
        f = 0;
        p = 1'b1;
        for (n = 0; n < 120; n++) begin
            @(negedge ref_clk);
            if (p && !port_data_bus_out[1]) f++;
            p = port_data_bus_out[1];
        end
        chk("steps", 8'(f), 8'h02);
        chk("seek busy", fd_seek_busy, 8'h00);
        chk("seek ready", fd_seek_ready, 8'h01);
        fd_write_en = 1;
        repeat (3) @(negedge ref_clk);
        chk("gate on", port_data_bus_out[3], 8'h00);
        fd_flux_write = 1;
        @(negedge ref_clk);
        fd_flux_write = 0;
        for (n = 0; n < 8 && port_data_bus_out[2]; n++) @(negedge ref_clk);
        chk("wdata", port_data_bus_out[2], 8'h00);
        flux_n = 0;
        for (n = 0; n < 8 && !fd_flux_pulse; n++) @(negedge ref_clk);
        chk("flux", fd_flux_pulse, 8'h01);
        flux_n = 1;
        fd_write_en = 0;
        repeat (3) @(negedge ref_clk);
        chk("gate off", port_data_bus_out[3], 8'h01);
        clk_en = 0;
        fd_write_en = 1;
        repeat (3) @(negedge ref_clk);
        chk("frozen gate", port_data_bus_out[3], 8'h01);
        {clk_en, fd_write_en} = 2'h2;
        $display("floppy test done");
    endtask
    initial begin
        t_par();
        t_fd();
        report_and_stop();
    end
    // Watchdog well past the expected few hundred cycles
    initial begin
        #200000;
        error_cnt++;
        report_and_stop();
    end
endmodule
`default_nettype wire
